// ### hw/cep_pkg.sv
// Package for the exception prioritizer: cause codes, priority list,
// opcode classes and debug control layout.
// Assumes a single core clock domain; no software-visible registers.
package cep_pkg;

    // Cause slots, index 0 is the highest priority
    localparam int CEP_NUM_CAUSE = 22;
    localparam int CEP_CODE_W    = 5;

    localparam logic [4:0] CEP_C_RESET    = 5'h00;
    localparam logic [4:0] CEP_C_DSTEP    = 5'h01;
    localparam logic [4:0] CEP_C_DIRQ     = 5'h02;
    localparam logic [4:0] CEP_C_NMI      = 5'h03;
    localparam logic [4:0] CEP_C_IRQ      = 5'h04;
    localparam logic [4:0] CEP_C_DIFETCH  = 5'h05;
    localparam logic [4:0] CEP_C_FADDR    = 5'h06;
    localparam logic [4:0] CEP_C_IBUS     = 5'h07;
    localparam logic [4:0] CEP_C_DSWBRK   = 5'h08;
    localparam logic [4:0] CEP_C_SUPERVISOR_CALL_OPCODE  = 5'h09;
    localparam logic [4:0] CEP_C_BRK      = 5'h0A;
    localparam logic [4:0] CEP_C_RSVD     = 5'h0B;
    localparam logic [4:0] CEP_C_COPU     = 5'h0C;
    localparam logic [4:0] CEP_C_EXTU     = 5'h0D;
    localparam logic [4:0] CEP_C_OVF      = 5'h0E;
    localparam logic [4:0] CEP_C_TRAP     = 5'h0F;
    localparam logic [4:0] CEP_C_DDATA    = 5'h10;
    localparam logic [4:0] CEP_C_LADDR    = 5'h11;
    localparam logic [4:0] CEP_C_SADDR    = 5'h12;
    localparam logic [4:0] CEP_C_DBUS     = 5'h13;
    localparam logic [4:0] CEP_C_DLVAL    = 5'h14;
    localparam logic [4:0] CEP_C_NONE     = 5'h1F;

    // Opcode class presented by the execute stage
    localparam int CEP_OP_W = 3;
    localparam logic [2:0] CEP_OP_NONE    = 3'h0;
    localparam logic [2:0] CEP_OP_DBGBRK  = 3'h1;
    localparam logic [2:0] CEP_OP_SVCALL  = 3'h2;
    localparam logic [2:0] CEP_OP_BREAK   = 3'h3;
    localparam logic [2:0] CEP_OP_DBGRET  = 3'h4;
    localparam logic [2:0] CEP_OP_WAIT    = 3'h5;

    // Debug control: break request bit position
    localparam int CEP_DCTRL_W       = 8;
    localparam int CEP_DCTRL_BRK_BIT = 0;
    localparam logic [7:0] CEP_DCTRL_RST = 8'h00;

    // Which cause slots are debug exceptions
    localparam logic [21:0] CEP_DEBUG_MASK = 22'h110126;

    typedef enum logic [1:0] {
        CEP_MODE_NORMAL,
        CEP_MODE_DEBUG,
        CEP_MODE_WAIT
    } cep_mode_e;

endpackage

// ### hw/cep_prio_enc.sv
// Fixed priority encoder over the exception cause vector.
// Assumes bit 0 of the vector is the most urgent cause.
`timescale 1ns/100ps
module cep_prio_enc
    import cep_pkg::*;
(
    // Pending causes
    input  wire logic [CEP_NUM_CAUSE-1:0] pend,
    // Winner
    output logic                          any,
    output logic [CEP_CODE_W-1:0]         code,
    output logic [CEP_NUM_CAUSE-1:0]      onehot
);

    // Lowest index wins; scan downward so the last hit is the best
    always_comb begin
        any    = 1'b0;
        code   = CEP_C_NONE;
        onehot = '0;
        for (int i = CEP_NUM_CAUSE - 1; i >= 0; i--) begin
            if (pend[i]) begin
                any    = 1'b1;
                code   = CEP_CODE_W'(i);
                onehot = CEP_NUM_CAUSE'(1) << i;
            end
        end
    end

endmodule // cep_prio_enc

// ### hw/cep_dbg_ctrl.sv
// Debug control register holding the break request bit.
// Assumes the debug probe writes through a simple strobe port.
`timescale 1ns/100ps
module cep_dbg_ctrl
    import cep_pkg::*;
(
    // Clock and synchronised reset
    input  wire logic                   clk,
    input  wire logic                   rst_sync_b,
    // Probe write port
    input  wire logic                   wr_en,
    input  wire logic [CEP_DCTRL_W-1:0] wr_data,
    // Clear when debug irq is taken
    input  wire logic                   brk_taken,
    // State
    output logic [CEP_DCTRL_W-1:0]      ctrl_reg
);

    logic [CEP_DCTRL_W-1:0] ctrl_next;

    // Write set wins over the clear on taking, so no request is lost
    always_comb begin
        ctrl_next = ctrl_reg;
        if (brk_taken)
            ctrl_next[CEP_DCTRL_BRK_BIT] = 1'b0;
        if (wr_en)
            ctrl_next = wr_data;
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b)
            ctrl_reg <= CEP_DCTRL_RST;
        else
            ctrl_reg <= ctrl_next;
    end

endmodule // cep_dbg_ctrl

// ### hw/cep_prioritizer.sv
// Top of the exception prioritizer: gathers causes from the pipeline,
// selects one by fixed priority, tracks debug and power-down mode.
// Assumes all inputs synchronous to clk; cause inputs are levels valid
// in the cycle they are presented.
`timescale 1ns/100ps

// Functional notes
// - Several pending causes: take only the highest fixed priority one.
// - Reset exception on master clear pin or power-on reset.
// - Debug single step ranks just below reset.
// - Debug irq from external request pin or break request bit.
// - Non-maskable request ranks below debug irq.
// - Interrupt only for unmasked hardware or software request.
// - Instruction breakpoint match ranks below interrupts.
// - Misaligned or protected fetch gives fetch address error.
// - Bus error on fetch ranks below fetch address error.
// - Debug breakpoint opcode raises debug software break.
// - Supervisor call opcode raises system call, below debug break.
// - Break opcode raises break exception below system call.
// - Reserved opcode raises reserved-instruction exception.
// - Coprocessor opcode for disabled coprocessor raises unusable.
// - Extension opcode while disabled raises extension unusable.
// - Overflow raises overflow; true trap condition ranks just below.
// - Data address match or store address+value match: data break.
// - Misaligned or protected load gives load address error.
// - Misaligned or protected store ranks directly below load error.
// - Bus error on load or store ranks below store address error.
// - Load data value match is the lowest priority exception.
// - Debug exception enters debug mode until debug return opcode or reset exception.
module cep_prioritizer
    import cep_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    // Reset sources
    input  wire logic                   master_clear_pin_b,
    input  wire logic                   por_event,
    // Interrupt and debug requests
    input  wire logic                   nmi_req,
    input  wire logic [7:0]             irq_pend,
    input  wire logic [7:0]             irq_mask,
    input  wire logic                   irq_global_en,
    input  wire logic                   ext_debug_request_pin,
    input  wire logic                   single_step_en,
    input  wire logic                   instr_retire,
    // Probe write to debug control
    input  wire logic                   dctrl_wr_en,
    input  wire logic [CEP_DCTRL_W-1:0] dctrl_wr_data,
    // Fetch stage causes
    input  wire logic                   ifetch_bp_match,
    input  wire logic                   ifetch_misalign,
    input  wire logic                   ifetch_protect,
    input  wire logic                   ifetch_bus_error,
    // Execute stage causes
    input  wire logic [CEP_OP_W-1:0]    op_class,
    input  wire logic                   op_reserved,
    input  wire logic                   op_copro,
    input  wire logic                   copro_enabled,
    input  wire logic                   op_ext,
    input  wire logic                   ext_enabled,
    input  wire logic                   arith_overflow,
    input  wire logic                   trap_true,
    // Memory stage causes
    input  wire logic                   data_addr_match,
    input  wire logic                   store_addr_val_match,
    input  wire logic                   load_misalign,
    input  wire logic                   load_protect,
    input  wire logic                   store_misalign,
    input  wire logic                   store_protect,
    input  wire logic                   data_bus_error,
    input  wire logic                   load_value_match,
    // Results
    output logic                        exc_valid,
    output logic [CEP_CODE_W-1:0]       exc_code_reg,
    output logic                        debug_mode,
    output logic                        power_down_req,
    output logic [CEP_DCTRL_W-1:0]      dctrl_state
);

    logic                     rst_meta_reg;
    logic                     rst_sync_b;
    logic [CEP_NUM_CAUSE-1:0] pend;
    logic [CEP_NUM_CAUSE-1:0] win_oh;
    logic [CEP_CODE_W-1:0]    win_code;
    logic                     win_any;
    logic                     is_dbg;
    logic                     dbg_irq_src;
    cep_mode_e                mode_reg;
    cep_mode_e                mode_next;
    logic [CEP_CODE_W-1:0]    code_next;
    logic                     valid_reg;
    logic                     valid_next;

    // Reset release through two flops; assert is immediate
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_reg <= 1'b0;
            rst_sync_b   <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_b   <= rst_meta_reg;
        end
    end

    // Debug control register with the break request bit
    cep_dbg_ctrl u_dctrl (
        .clk        (clk),
        .rst_sync_b (rst_sync_b),
        .wr_en      (dctrl_wr_en),
        .wr_data    (dctrl_wr_data),
        .brk_taken  (win_any && win_code == CEP_C_DIRQ),
        .ctrl_reg   (dctrl_state)
    );

    assign dbg_irq_src = ext_debug_request_pin
                       | dctrl_state[CEP_DCTRL_BRK_BIT];

    // Cause vector in priority order; debug causes other than the debug break opcode only outside debug
    always_comb begin
        pend = '0;
        pend[CEP_C_RESET]   = !master_clear_pin_b || por_event;
        pend[CEP_C_DSTEP]   = single_step_en && instr_retire
                            && mode_reg != CEP_MODE_DEBUG;
        pend[CEP_C_DIRQ]    = dbg_irq_src
                            && mode_reg != CEP_MODE_DEBUG;
        pend[CEP_C_NMI]     = nmi_req;
        pend[CEP_C_IRQ]     = irq_global_en
                            && |(irq_pend & ~irq_mask);
        pend[CEP_C_DIFETCH] = ifetch_bp_match
                            && mode_reg != CEP_MODE_DEBUG;
        pend[CEP_C_FADDR]   = ifetch_misalign || ifetch_protect;
        pend[CEP_C_IBUS]    = ifetch_bus_error;
        pend[CEP_C_DSWBRK]  = op_class == CEP_OP_DBGBRK;
        pend[CEP_C_SUPERVISOR_CALL_OPCODE] = op_class == CEP_OP_SVCALL;
        pend[CEP_C_BRK]     = op_class == CEP_OP_BREAK;
        pend[CEP_C_RSVD]    = op_reserved;
        pend[CEP_C_COPU]    = op_copro && !copro_enabled;
        pend[CEP_C_EXTU]    = op_ext && !ext_enabled;
        pend[CEP_C_OVF]     = arith_overflow;
        pend[CEP_C_TRAP]    = trap_true;
        pend[CEP_C_DDATA]   = (data_addr_match || store_addr_val_match)
                            && mode_reg != CEP_MODE_DEBUG;
        pend[CEP_C_LADDR]   = load_misalign || load_protect;
        pend[CEP_C_SADDR]   = store_misalign || store_protect;
        pend[CEP_C_DBUS]    = data_bus_error;
        pend[CEP_C_DLVAL]   = load_value_match
                            && mode_reg != CEP_MODE_DEBUG;
    end

    // One winner from the fixed order
    cep_prio_enc u_enc (
        .pend   (pend),
        .any    (win_any),
        .code   (win_code),
        .onehot (win_oh)
    );

    assign is_dbg = |(win_oh & CEP_DEBUG_MASK);

    // Mode and result next state; exceptions outrank wait and return
    always_comb begin
        mode_next  = mode_reg;
        code_next  = exc_code_reg;
        valid_next = win_any;
        if (win_any) begin
            code_next = win_code;
            if (win_code == CEP_C_RESET)
                mode_next = CEP_MODE_NORMAL;
            else if (is_dbg)
                mode_next = CEP_MODE_DEBUG;
            else if (mode_reg == CEP_MODE_WAIT)
                mode_next = CEP_MODE_NORMAL; // Wake on any exception
        end else begin
            case (mode_reg)
                CEP_MODE_DEBUG: begin
                    if (op_class == CEP_OP_DBGRET)
                        mode_next = CEP_MODE_NORMAL;
                end
                CEP_MODE_NORMAL: begin
                    if (op_class == CEP_OP_WAIT)
                        mode_next = CEP_MODE_WAIT;
                end
                CEP_MODE_WAIT: mode_next = CEP_MODE_WAIT;
                default: mode_next = CEP_MODE_NORMAL;
            endcase
        end
    end

    // Static state: holds through a slowed or stopped clock
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            mode_reg     <= CEP_MODE_NORMAL;
            exc_code_reg <= CEP_C_NONE;
            valid_reg    <= 1'b0;
        end else begin
            mode_reg     <= mode_next;
            exc_code_reg <= code_next;
            valid_reg    <= valid_next;
        end
    end

    assign exc_valid      = valid_reg;
    assign debug_mode     = mode_reg == CEP_MODE_DEBUG;
    assign power_down_req = mode_reg == CEP_MODE_WAIT;

    // Checks
    property p_reset_wins;
        @(posedge clk) disable iff (!rst_sync_b)
        (!master_clear_pin_b || por_event) |=>
            exc_valid && exc_code_reg == CEP_C_RESET;
    endproperty
    a_reset_wins: assert property (p_reset_wins)
        else $error("reset cause not taken");

    property p_nmi_over_irq;
        @(posedge clk) disable iff (!rst_sync_b)
        (nmi_req && master_clear_pin_b && !por_event && pend[2:1] == 2'b00)
            |=> exc_code_reg == CEP_C_NMI;
    endproperty
    a_nmi_over_irq: assert property (p_nmi_over_irq)
        else $error("nmi not chosen");

    property p_masked_irq;
        @(posedge clk) disable iff (!rst_sync_b)
        (pend[3:0] == 4'h0 && pend[5]
            && (!irq_global_en || (irq_pend & ~irq_mask) == 8'h00))
            |=> exc_code_reg == CEP_C_DIFETCH;
    endproperty
    a_masked_irq: assert property (p_masked_irq)
        else $error("instruction break lost");

    property p_one_winner;
        @(posedge clk) disable iff (!rst_sync_b)
        win_any |-> $onehot(win_oh) && ((pend & (win_oh - 22'h1)) == '0);
    endproperty
    a_one_winner: assert property (p_one_winner)
        else $error("winner not highest");

    property p_dbg_enter;
        @(posedge clk) disable iff (!rst_sync_b)
        (win_any && is_dbg && win_code != CEP_C_RESET) |=> debug_mode;
    endproperty
    a_dbg_enter: assert property (p_dbg_enter)
        else $error("debug mode not entered");

    property p_dbg_stay;
        @(posedge clk) disable iff (!rst_sync_b)
        (debug_mode && op_class != CEP_OP_DBGRET && !pend[0]) |=> debug_mode;
    endproperty
    a_dbg_stay: assert property (p_dbg_stay)
        else $error("debug mode left early");

    property p_wait_req;
        @(posedge clk) disable iff (!rst_sync_b)
        (mode_reg == CEP_MODE_NORMAL && op_class == CEP_OP_WAIT && !win_any)
            |=> power_down_req ##1 (power_down_req || exc_valid);
    endproperty
    a_wait_req: assert property (p_wait_req)
        else $error("power-down not requested");

    property p_store_below_load;
        @(posedge clk) disable iff (!rst_sync_b)
        (pend[CEP_C_SADDR] && pend[CEP_C_LADDR] && pend[16:0] == 17'h0)
            |=> exc_code_reg == CEP_C_LADDR;
    endproperty
    a_store_below_load: assert property (p_store_below_load)
        else $error("store error outranked load");

    property p_step_first;
        @(posedge clk) disable iff (!rst_sync_b)
        (!pend[0] && pend[1]) |=> exc_code_reg == CEP_C_DSTEP;
    endproperty
    a_step_first: assert property (p_step_first)
        else $error("single step lost");

    property p_dirq_src;
        @(posedge clk) disable iff (!rst_sync_b)
        (pend[1:0] == 2'b00 && !debug_mode && dbg_irq_src)
            |=> exc_code_reg == CEP_C_DIRQ && debug_mode;
    endproperty
    a_dirq_src: assert property (p_dirq_src)
        else $error("debug irq lost");

    property p_dbg_exit;
        @(posedge clk) disable iff (!rst_sync_b)
        (debug_mode && op_class == CEP_OP_DBGRET && !win_any) |=> !debug_mode;
    endproperty
    a_dbg_exit: assert property (p_dbg_exit)
        else $error("debug not left");

    property p_wait_wake;
        @(posedge clk) disable iff (!rst_sync_b)
        (power_down_req && win_any) |=> exc_valid && !power_down_req;
    endproperty
    a_wait_wake: assert property (p_wait_wake)
        else $error("wait not left");

endmodule // cep_prioritizer

// ### sim/cep_far_model.sv
// Far-side model: pipeline stages, interrupt controller and debug
// probe, turning a requested set of cause slots into pin levels.
// Assumes want and sel change only just after a clock edge.
`timescale 1ns/100ps
module cep_far_model
    import cep_pkg::*;
(
    // Requested slots and spare choice bits
    input  wire logic [CEP_NUM_CAUSE-1:0] want,
    input  wire logic [31:0]              sel,
    // Reset, request and fetch pins
    output logic       master_clear_pin_b, por_event, nmi_req,
    output logic       ext_debug_request_pin, single_step_en,
    output logic       instr_retire, irq_global_en,
    output logic [7:0] irq_pend, irq_mask,
    output logic       ifetch_bp_match, ifetch_misalign,
    output logic       ifetch_protect, ifetch_bus_error,
    // Execute and memory stage pins
    output logic       op_reserved, op_copro, copro_enabled, op_ext,
    output logic       ext_enabled, arith_overflow, trap_true,
    output logic       data_addr_match, store_addr_val_match,
    output logic       load_misalign, load_protect, store_misalign,
    output logic       store_protect, data_bus_error, load_value_match
);
    logic [7:0] irq_line;

    // Unrequested slots still see decoy pins that must stay harmless
    always_comb begin
        irq_line = 8'h01 << sel[18:16];
        master_clear_pin_b = ~(want[0] & sel[0]);
        por_event = want[0] & ~sel[0];
        single_step_en = want[1] | sel[1];
        instr_retire = want[1] | (~sel[1] & sel[2]);
        ext_debug_request_pin = want[2];
        nmi_req = want[3];
        // Masked or globally disabled lines act as decoys
        irq_global_en = want[4] | sel[19];
        irq_pend = sel[15:8] | (want[4] ? irq_line : 8'h00);
        irq_mask = sel[19] ? 8'hFF : sel[27:20];
        if (want[4]) begin
            irq_mask = ~irq_line;
        end
        ifetch_bp_match = want[5];
        ifetch_misalign = want[6] & sel[3];
        ifetch_protect = want[6] & (~sel[3] | sel[4]);
        ifetch_bus_error = want[7];
        op_reserved = want[11];
        // Enabled units make these opcodes harmless
        op_copro = want[12] | sel[5];
        copro_enabled = ~want[12];
        op_ext = want[13] | sel[6];
        ext_enabled = ~want[13];
        arith_overflow = want[14];
        trap_true = want[15];
        data_addr_match = want[16] & sel[7];
        store_addr_val_match = want[16] & ~sel[7];
        load_misalign = want[17] & sel[28];
        load_protect = want[17] & ~sel[28];
        store_misalign = want[18] & sel[29];
        store_protect = want[18] & ~sel[29];
        data_bus_error = want[19];
        load_value_match = want[20];
    end
endmodule // cep_far_model

// ### sim/tb_top.sv
// Self-checking bench for the exception prioritizer with a reference
// model that predicts every registered result from the cause pins.
// Assumes one 40 MHz clock; the far-side model drives the cause pins.
`timescale 1ns/100ps
module tb_top;
    import cep_pkg::*;
    logic                     clk, rst_b, dctrl_wr_en;
    logic [CEP_DCTRL_W-1:0]   dctrl_wr_data, dctrl_state;
    logic [CEP_OP_W-1:0]      op_class, op;
    logic [CEP_NUM_CAUSE-1:0] want, wv;
    logic [31:0]              sel, seed_tmp;
    logic                     master_clear_pin_b, por_event, nmi_req;
    logic                     ext_debug_request_pin, single_step_en;
    logic                     instr_retire, irq_global_en;
    logic [7:0]               irq_pend, irq_mask;
    logic                     ifetch_bp_match, ifetch_misalign;
    logic                     ifetch_protect, ifetch_bus_error;
    logic                     op_reserved, op_copro, copro_enabled;
    logic                     op_ext, ext_enabled, arith_overflow;
    logic                     trap_true, data_addr_match;
    logic                     store_addr_val_match, load_misalign;
    logic                     load_protect, store_misalign, store_protect;
    logic                     data_bus_error, load_value_match;
    logic                     exc_valid, debug_mode, power_down_req;
    logic [CEP_CODE_W-1:0]    exc_code_reg, m_code;
    logic                     m_dbg, m_pd, m_brk, m_valid;
    int                       fails = 0;
    int                       samples_checked = 0;
    int                       i;
    int                       dbg_slots[5] = '{1, 2, 5, 16, 20};

    cep_far_model cep_far_model_i (
        .want, .sel, .master_clear_pin_b, .por_event, .nmi_req,
        .ext_debug_request_pin, .single_step_en, .instr_retire,
        .irq_global_en, .irq_pend, .irq_mask, .ifetch_bp_match,
        .ifetch_misalign, .ifetch_protect, .ifetch_bus_error, .op_reserved,
        .op_copro, .copro_enabled, .op_ext, .ext_enabled, .arith_overflow,
        .trap_true, .data_addr_match, .store_addr_val_match, .load_misalign,
        .load_protect, .store_misalign, .store_protect, .data_bus_error,
        .load_value_match
    );
    cep_prioritizer cep_prioritizer_i (
        .clk, .rst_b, .master_clear_pin_b, .por_event, .nmi_req, .irq_pend,
        .irq_mask, .irq_global_en, .ext_debug_request_pin, .single_step_en,
        .instr_retire, .dctrl_wr_en, .dctrl_wr_data, .ifetch_bp_match,
        .ifetch_misalign, .ifetch_protect, .ifetch_bus_error, .op_class,
        .op_reserved, .op_copro, .copro_enabled, .op_ext, .ext_enabled,
        .arith_overflow, .trap_true, .data_addr_match, .store_addr_val_match,
        .load_misalign, .load_protect, .store_misalign, .store_protect,
        .data_bus_error, .load_value_match, .exc_valid, .exc_code_reg,
        .debug_mode, .power_down_req, .dctrl_state
    );

    // 25 ns core clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic end_sim();
        if (fails == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Compare helpers, one per result width
    task automatic chk_bit(input string nm, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk_code(input string nm, input logic [4:0] e,
                            input logic [4:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_ctrl(input string nm, input logic [7:0] e,
                            input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Reference model: pending slots from the pins, lowest index wins
    task automatic predict();
        logic [CEP_NUM_CAUSE-1:0] p;
        int w;
        p = '0;
        w = -1;
        p[0] = ~master_clear_pin_b | por_event;
        p[1] = ~m_dbg & single_step_en & instr_retire;
        p[2] = ~m_dbg & (ext_debug_request_pin | m_brk);
        p[3] = nmi_req;
        p[4] = irq_global_en & (|(irq_pend & ~irq_mask));
        p[5] = ~m_dbg & ifetch_bp_match;
        p[6] = ifetch_misalign | ifetch_protect;
        p[7] = ifetch_bus_error;
        p[8] = (op_class == CEP_OP_DBGBRK);
        p[9] = (op_class == CEP_OP_SVCALL);
        p[10] = (op_class == CEP_OP_BREAK);
        p[11] = op_reserved;
        p[12] = op_copro & ~copro_enabled;
        p[13] = op_ext & ~ext_enabled;
        p[14] = arith_overflow;
        p[15] = trap_true;
        p[16] = ~m_dbg & (data_addr_match | store_addr_val_match);
        p[17] = load_misalign | load_protect;
        p[18] = store_misalign | store_protect;
        p[19] = data_bus_error;
        p[20] = ~m_dbg & load_value_match;
        for (int k = CEP_NUM_CAUSE - 1; k >= 0; k--) begin
            if (p[k]) w = k;
        end
        m_valid = (w >= 0);
        if (w >= 0) begin
            m_code = w[4:0];
            m_pd = 1'b0;
        end else if (op_class == CEP_OP_WAIT && !m_dbg) begin
            m_pd = 1'b1;
        end
        if (p[0]) begin
            m_dbg = 1'b0;
        end else if (w >= 0 && CEP_DEBUG_MASK[w]) begin
            m_dbg = 1'b1;
        end else if (w < 0 && op_class == CEP_OP_DBGRET) begin
            m_dbg = 1'b0;
        end
        if (dctrl_wr_en) begin
            m_brk = dctrl_wr_data[CEP_DCTRL_BRK_BIT];
        end else if (w == 2) begin
            m_brk = 1'b0;
        end
    endtask

    // One cycle: drive, predict, let the edge land, compare
    task automatic cyc(input logic [CEP_NUM_CAUSE-1:0] v,
                       input logic [CEP_OP_W-1:0] o, input logic wr);
        want = v;
        op_class = o;
        sel = $urandom();
        dctrl_wr_en = wr;
        dctrl_wr_data = {7'h00, wr};
        #1;
        predict();
        @(posedge clk);
        #2;
        chk_bit("exc_valid", m_valid, exc_valid);
        chk_code("exc_code_reg", m_code, exc_code_reg);
        chk_bit("debug_mode", m_dbg, debug_mode);
        chk_bit("power_down_req", m_pd, power_down_req);
    endtask

    function automatic logic [CEP_OP_W-1:0] op_of(
        input logic [CEP_NUM_CAUSE-1:0] v);
        if (v[8]) return CEP_OP_DBGBRK;
        if (v[9]) return CEP_OP_SVCALL;
        if (v[10]) return CEP_OP_BREAK;
        return CEP_OP_NONE;
    endfunction

    // Idle cycle, then leave debug mode if the model is in it
    task automatic settle();
        cyc('0, CEP_OP_NONE, 1'b0);
        if (m_dbg) begin
            cyc('0, CEP_OP_DBGRET, 1'b0);
        end
    endtask

    // Hang guard well beyond the planned run
    initial begin
        #2500000;
        fails++;
        end_sim();
    end

    // Main sequence
    initial begin
        seed_tmp = $urandom(32'h8F684AB7);
        rst_b = 1'b0;
        want = '0;
        sel = '0;
        op_class = CEP_OP_NONE;
        dctrl_wr_en = 1'b0;
        dctrl_wr_data = '0;
        m_dbg = 1'b0;
        m_pd = 1'b0;
        m_brk = 1'b0;
        m_code = CEP_C_NONE;
        repeat (3) @(posedge clk);
        #2;
        rst_b = 1'b1;
        repeat (3) @(posedge clk);
        #2;
        chk_bit("exc_valid", 1'b0, exc_valid);
        chk_code("exc_code_reg", CEP_C_NONE, exc_code_reg);
        chk_bit("power_down_req", 1'b0, power_down_req);
        chk_ctrl("dctrl_state", CEP_DCTRL_RST, dctrl_state);
        // Every slot alone, then against its next lower neighbour; slots 8, 9 and 10 share op_class and slot 20 has none, so pairs from 8, 9 and 20 run alone
        for (i = 0; i < 21; i++) begin
            cyc(22'h1 << i, op_of(22'h1 << i), 1'b0);
            settle();
            cyc(22'h3 << i, op_of(22'h3 << i), 1'b0);
            settle();
        end
        // Debug causes ignored in debug mode, debug break opcode is not
        cyc(22'h4, CEP_OP_NONE, 1'b0);
        foreach (dbg_slots[k]) begin
            cyc(22'h1 << dbg_slots[k], CEP_OP_NONE, 1'b0);
        end
        cyc(22'h100, CEP_OP_DBGBRK, 1'b0);
        settle();
        // Power-down request, then woken by an interrupt
        cyc('0, CEP_OP_WAIT, 1'b0);
        cyc('0, CEP_OP_NONE, 1'b0);
        cyc(22'h10, CEP_OP_NONE, 1'b0);
        // Break request bit from the probe port
        cyc('0, CEP_OP_NONE, 1'b1);
        chk_ctrl("dctrl_state", 8'h01, dctrl_state);
        cyc('0, CEP_OP_NONE, 1'b0);
        cyc('0, CEP_OP_NONE, 1'b0);
        settle();
        chk_ctrl("dctrl_state", 8'h00, dctrl_state);
        // Random mixes; wait and debug return opcodes only with no cause pending
        for (i = 0; i < 4000; i++) begin
            for (int k = 0; k < 21; k++) begin
                wv[k] = ($urandom_range(0, 19) == 0);
            end
            wv[21] = 1'b0;
            op = op_of(wv);
            if (op == CEP_OP_NONE && $urandom_range(0, 5) == 0) begin
                wv = '0;
                op = m_dbg ? CEP_OP_DBGRET : CEP_OP_WAIT;
            end
            cyc(wv, op, 1'b0);
        end
        end_sim();
    end
endmodule // tb_top
